// >>> inc/slx_defs.svh
// Register offsets, field positions, reset values and error counter width and limit
// for the lane crossbar and bit-error test block.
// Assumes a 32-bit Avalon-MM bus with byte addresses; byte address = 4 * index.
`ifndef SLX_DEFS_SVH
`define SLX_DEFS_SVH

// Register indices
`define SLX_IDX_ROUTE_0_1 10'h308
`define SLX_IDX_ROUTE_2_3 10'h309
`define SLX_IDX_ROUTE_4_5 10'h30A
`define SLX_IDX_ROUTE_6_7 10'h30B
`define SLX_IDX_BUF_FULL 10'h30C
`define SLX_IDX_BUF_EMPTY 10'h30D
`define SLX_IDX_SYNC_CFG 10'h312
`define SLX_IDX_PHY_SETUP 10'h314
`define SLX_IDX_TEST_EN 10'h315
`define SLX_IDX_TEST_CTRL 10'h316
`define SLX_IDX_THR_LO 10'h317
`define SLX_IDX_THR_MID 10'h318
`define SLX_IDX_THR_HI 10'h319
`define SLX_IDX_CNT_LO 10'h31A
`define SLX_IDX_CNT_MID 10'h31B
`define SLX_IDX_CNT_HI 10'h31C
`define SLX_IDX_PASS 10'h31D

// Field positions
`define SLX_ROUTE_LO 2:0
`define SLX_ROUTE_HI 5:3
`define SLX_SYNC_DUR 5:4
`define SLX_CTRL_SRC 6:4
`define SLX_CTRL_PAT 3:2
`define SLX_CTRL_RUN 1
`define SLX_CTRL_CLR 0

// Reset values
`define SLX_RST_SYNC_DUR 2'h1
`define SLX_RST_PHY_SETUP 8'h00
`define SLX_RST_TEST_EN 8'h00
`define SLX_RST_PASS 8'hFF

// Error counter
`define SLX_CNT_W 24
`define SLX_CNT_MAX 24'hFFFFFF

`endif

// >>> inc/slx_pkg.sv
// Types shared by the lane crossbar and bit-error test block.
// Assumes nothing of its surroundings.
package slx_pkg;

	typedef enum logic [1:0] {
		SLX_PAT_PRBS7 = 2'h0,
		SLX_PAT_PRBS15 = 2'h1,
		SLX_PAT_PRBS31 = 2'h2
	} slx_pattern_t;

	typedef enum logic {
		SLX_SYNC_IDLE,
		SLX_SYNC_LOW
	} slx_sync_state_t;

endpackage : slx_pkg

// >>> src/slx_lane_xbar.sv
// Lane crossbar, buffer status, sync error pulse and per-lane bit-error test.
// Assumes an Avalon-MM master on clk_sys, one serial bit per lane per clock,
// and error, buffer and multiframe signals produced on clk_sys.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "slx_defs.svh"

module slx_lane_xbar
	import slx_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] physical_serial_input,
	output logic [7:0] logical_lane_data,
	input wire logic [7:0] lane_buffer_full,
	input wire logic [7:0] lane_buffer_empty,
	input wire logic multiframe_end,
	input wire logic [7:0] disparity_error,
	input wire logic [7:0] not_in_table_error,
	input wire logic [7:0] unexpected_control_error,
	output logic [1:0] sync_request_output_n,
	output logic [7:0] serial_phy_setup_value
);

	// ****************************************
	// Functions
	// ****************************************

	// Expected next bit from the last received bits, for a self-seeding checker
	function automatic logic prbs_predict(input logic [30:0] hist, input logic [1:0] pat);
		logic bit_out;
		bit_out = 1'b0;
		case (pat)
			SLX_PAT_PRBS7: bit_out = hist[6] ^ hist[5];
			SLX_PAT_PRBS15: bit_out = hist[14] ^ hist[13];
			SLX_PAT_PRBS31: bit_out = hist[30] ^ hist[27];
			default: bit_out = hist[6] ^ hist[5];
		endcase
		return bit_out;
	endfunction : prbs_predict

	// Two 3-bit source fields share one byte; the upper two bits read zero
	function automatic logic [7:0] pack_route(input logic [2:0] hi, input logic [2:0] lo);
		return {2'h0, hi, lo};
	endfunction : pack_route

	// ****************************************
	// Input synchronisers
	// ****************************************

	// Only the second stage feeds logic; the first may still be settling
	logic [7:0] serial_meta_q;
	logic [7:0] serial_sync_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			serial_meta_q <= 8'h00;
			serial_sync_q <= 8'h00;
		end else begin
			serial_meta_q <= physical_serial_input;
			serial_sync_q <= serial_meta_q;
		end
	end

	// ****************************************
	// Register bus
	// ****************************************

	logic ack_q;
	logic [31:0] readdata_q;
	logic [2:0] route_q [8];
	logic [1:0] sync_dur_q;
	logic [7:0] phy_setup_q;
	logic [7:0] test_en_q;
	logic [2:0] cnt_src_q;
	logic [1:0] pattern_q;
	logic run_q;
	logic clear_q;
	logic [23:0] threshold_q;
	logic [23:0] err_cnt_q [8];
	logic [7:0] pass_q;

	wire [9:0] reg_idx = avs_address[11:2];
	wire bus_req = avs_read | avs_write;
	// Read data is captured at the decode edge and held for the answer cycle
	wire rd_capture = avs_read & ~ack_q;
	// Write commits only at the edge where waitrequest is low
	wire wr_commit = avs_write & ack_q & avs_byteenable[0];
	wire [7:0] wr_byte = avs_writedata[7:0];
	wire [23:0] sel_cnt = err_cnt_q[cnt_src_q];
	wire wr_route01 = wr_commit & (reg_idx == `SLX_IDX_ROUTE_0_1);
	wire wr_route23 = wr_commit & (reg_idx == `SLX_IDX_ROUTE_2_3);
	wire wr_route45 = wr_commit & (reg_idx == `SLX_IDX_ROUTE_4_5);
	wire wr_route67 = wr_commit & (reg_idx == `SLX_IDX_ROUTE_6_7);
	wire [3:0] wr_route = {wr_route67, wr_route45, wr_route23, wr_route01};

	logic [7:0] rd_byte;

	always_comb begin
		rd_byte = 8'h00;
		case (reg_idx)
			`SLX_IDX_ROUTE_0_1: rd_byte = pack_route(route_q[1], route_q[0]);
			`SLX_IDX_ROUTE_2_3: rd_byte = pack_route(route_q[3], route_q[2]);
			`SLX_IDX_ROUTE_4_5: rd_byte = pack_route(route_q[5], route_q[4]);
			`SLX_IDX_ROUTE_6_7: rd_byte = pack_route(route_q[7], route_q[6]);
			`SLX_IDX_BUF_FULL: rd_byte = lane_buffer_full;
			`SLX_IDX_BUF_EMPTY: rd_byte = lane_buffer_empty;
			`SLX_IDX_SYNC_CFG: rd_byte = {2'h0, sync_dur_q, 4'h0};
			`SLX_IDX_PHY_SETUP: rd_byte = phy_setup_q;
			`SLX_IDX_TEST_EN: rd_byte = test_en_q;
			`SLX_IDX_TEST_CTRL: rd_byte = {1'b0, cnt_src_q, pattern_q, run_q, clear_q};
			`SLX_IDX_THR_LO: rd_byte = threshold_q[7:0];
			`SLX_IDX_THR_MID: rd_byte = threshold_q[15:8];
			`SLX_IDX_THR_HI: rd_byte = threshold_q[23:16];
			`SLX_IDX_CNT_LO: rd_byte = sel_cnt[7:0];
			`SLX_IDX_CNT_MID: rd_byte = sel_cnt[15:8];
			`SLX_IDX_CNT_HI: rd_byte = sel_cnt[23:16];
			`SLX_IDX_PASS: rd_byte = pass_q;
			default: rd_byte = 8'h00;
		endcase
	end

	// One wait cycle per access, so read data is sampled a full cycle after decode
	assign avs_waitrequest = bus_req & ~ack_q;
	assign avs_readdata = readdata_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (rd_capture) begin
				readdata_q <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Routing fields come up as the identity map
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 8; i++) begin
				route_q[i] <= 3'(i);
			end
		end else begin
			for (int p = 0; p < 4; p++) begin
				if (wr_route[p]) begin
					route_q[2 * p] <= wr_byte[`SLX_ROUTE_LO];
					route_q[2 * p + 1] <= wr_byte[`SLX_ROUTE_HI];
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync_dur_q <= `SLX_RST_SYNC_DUR;
			phy_setup_q <= `SLX_RST_PHY_SETUP;
			test_en_q <= `SLX_RST_TEST_EN;
			cnt_src_q <= 3'h0;
			pattern_q <= 2'h0;
			run_q <= 1'b0;
			clear_q <= 1'b0;
			threshold_q <= 24'h00_0000;
		end else if (wr_commit) begin
			case (reg_idx)
				`SLX_IDX_SYNC_CFG: sync_dur_q <= wr_byte[`SLX_SYNC_DUR];
				`SLX_IDX_PHY_SETUP: phy_setup_q <= wr_byte;
				`SLX_IDX_TEST_EN: test_en_q <= wr_byte;
				`SLX_IDX_TEST_CTRL: begin
					cnt_src_q <= wr_byte[`SLX_CTRL_SRC];
					pattern_q <= wr_byte[`SLX_CTRL_PAT];
					run_q <= wr_byte[`SLX_CTRL_RUN];
					clear_q <= wr_byte[`SLX_CTRL_CLR];
				end
				`SLX_IDX_THR_LO: threshold_q[7:0] <= wr_byte;
				`SLX_IDX_THR_MID: threshold_q[15:8] <= wr_byte;
				`SLX_IDX_THR_HI: threshold_q[23:16] <= wr_byte;
				default: threshold_q <= threshold_q;
			endcase
		end
	end

	// The copy drives the lane receivers directly; software owns its value
	assign serial_phy_setup_value = phy_setup_q;

	// ****************************************
	// Lane crossbar
	// ****************************************

	// Two sync stages plus this register: three clocks from pin to lane
	logic [7:0] lane_data_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lane_data_q <= 8'h00;
		end else begin
			for (int l = 0; l < 8; l++) begin
				lane_data_q[l] <= serial_sync_q[route_q[l]];
			end
		end
	end

	assign logical_lane_data = lane_data_q;

	// ****************************************
	// Sync error pulse
	// ****************************************

	slx_sync_state_t sync_state_q;
	logic err_seen_q;
	logic [1:0] low_cnt_q;

	wire [7:0] any_lane_err = disparity_error | not_in_table_error | unexpected_control_error;
	wire any_coding_err = |any_lane_err;
	// An error in the closing cycle still counts for this multiframe
	wire fire_sync = multiframe_end & (err_seen_q | any_coding_err);
	// Half a cycle cannot be made on one edge; values 0 and 1 both give one cycle
	wire [1:0] low_len = (sync_dur_q >= 2'h2) ? 2'h2 : 2'h1;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync_state_q <= SLX_SYNC_IDLE;
			err_seen_q <= 1'b0;
			low_cnt_q <= 2'h0;
		end else begin
			err_seen_q <= multiframe_end ? 1'b0 : (err_seen_q | any_coding_err);
			// A multiframe end that arrives while the outputs are low is not queued
			case (sync_state_q)
				SLX_SYNC_IDLE: begin
					if (fire_sync) begin
						sync_state_q <= SLX_SYNC_LOW;
						low_cnt_q <= low_len - 2'h1;
					end
				end
				SLX_SYNC_LOW: begin
					if (low_cnt_q == 2'h0) begin
						sync_state_q <= SLX_SYNC_IDLE;
					end else begin
						low_cnt_q <= low_cnt_q - 2'h1;
					end
				end
				default: sync_state_q <= SLX_SYNC_IDLE;
			endcase
		end
	end

	// Both sync outputs pulse together
	assign sync_request_output_n = (sync_state_q == SLX_SYNC_LOW) ? 2'b00 : 2'b11;

	// ****************************************
	// Bit-error test
	// ****************************************

	logic [30:0] hist_q [8];
	logic [7:0] mismatch;
	logic [7:0] lane_active;

	always_comb begin
		for (int k = 0; k < 8; k++) begin
			lane_active[k] = run_q & ~clear_q & test_en_q[k];
			mismatch[k] = serial_sync_q[k] ^ prbs_predict(hist_q[k], pattern_q);
		end
	end

	// The checker seeds itself from received bits, so early errors may appear
	// until the history fills; clear the counters after the link settles.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 8; i++) begin
				hist_q[i] <= 31'h0000_0000;
				err_cnt_q[i] <= 24'h00_0000;
			end
			pass_q <= `SLX_RST_PASS;
		end else if (clear_q) begin
			for (int i = 0; i < 8; i++) begin
				hist_q[i] <= 31'h0000_0000;
				err_cnt_q[i] <= 24'h00_0000;
			end
			pass_q <= `SLX_RST_PASS;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (lane_active[i]) begin
					hist_q[i] <= {hist_q[i][29:0], serial_sync_q[i]};
					if (mismatch[i] && err_cnt_q[i] != `SLX_CNT_MAX) begin
						err_cnt_q[i] <= err_cnt_q[i] + 24'h00_0001;
					end
					// Pass flags keep their last value once run or the lane enable drops; clear sets them all to one
					pass_q[i] <= (err_cnt_q[i] < threshold_q);
				end
			end
		end
	end

endmodule : slx_lane_xbar
`default_nettype wire

// >>> verification/slx_sva.sv
// Checker for the lane crossbar block ports.
// Assumes binding to slx_lane_xbar, one clock.
`timescale 1ns/100ps
`default_nettype none
module slx_sva_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [7:0] lane_buffer_full,
	input wire logic [7:0] lane_buffer_empty,
	input wire logic multiframe_end,
	input wire logic [7:0] disparity_error,
	input wire logic [7:0] not_in_table_error,
	input wire logic [7:0] unexpected_control_error,
	input wire logic [1:0] sync_request_output_n,
	input wire logic [7:0] serial_phy_setup_value
);
	// *******
	// Helpers
	// *******
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic err_q;
	logic [1:0] dur_q;
	wire [1:0] sy = sync_request_output_n;
	wire [9:0] ix = avs_address[11:2];
	wire take = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire err = |{disparity_error, not_in_table_error, unexpected_control_error};
	wire rd0 = avs_read & avs_waitrequest;
	// Error seen anywhere in the multiframe, cleared at its end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			err_q <= 1'b0;
			dur_q <= 2'h1;
		end else begin
			err_q <= ~multiframe_end & (err_q | err);
			if (take && ix == 10'h312)
				dur_q <= avs_writedata[5:4];
		end
	end
	sequence low1; sy == 2'b00 ##1 sy == 2'b11; endsequence
	sequence low2; sy == 2'b00 [*2] ##1 sy == 2'b11; endsequence
	// **********
	// Assertions
	// **********
	wait_first_a: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
		else $error("no wait cycle");
	one_wait_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait too long");
	sync_fire_a: assert property (multiframe_end && (err | err_q) && sy == 2'b11 |=> sy == 2'b00)
		else $error("no sync error");
	sync_quiet_a: assert property (multiframe_end && !(err | err_q) && sy == 2'b11 |=> sy == 2'b11)
		else $error("sync error without cause");
	len_short_a: assert property ($fell(sy[0]) && dur_q < 2'h2 |-> low1)
		else $error("short pulse length");
	len_long_a: assert property ($fell(sy[0]) && dur_q >= 2'h2 |-> low2)
		else $error("long pulse length");
	sync_pair_a: assert property (sy[0] == sy[1])
		else $error("sync outputs differ");
	phy_copy_a: assert property (take && ix == 10'h314 |=> serial_phy_setup_value == $past(avs_writedata[7:0]))
		else $error("phy setup copy");
	full_read_a: assert property (rd0 && ix == 10'h30C |=> avs_readdata[7:0] == $past(lane_buffer_full))
		else $error("full flags read");
	empty_read_a: assert property (rd0 && ix == 10'h30D |=> avs_readdata[7:0] == $past(lane_buffer_empty))
		else $error("empty flags read");
endmodule : slx_sva_chk
`default_nettype wire

// >>> verification/slx_tx_model.sv
// Far-end lane transmitter model: PRBS7 on all lanes or a static word.
// Assumes flip and word change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module slx_tx_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic prbs_on,
	input wire logic [7:0] word,
	input wire logic [7:0] flip,
	output logic [7:0] lanes
);
	// *****
	// PRBS7
	// *****
	logic [6:0] s_q;
	wire nb = s_q[6] ^ s_q[5];
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= 7'h7F;
			lanes <= 8'h00;
		end else begin
			s_q <= {s_q[5:0], nb};
			// Flip injects single bit errors on chosen lanes
			lanes <= prbs_on ? ({8{nb}} ^ flip) : word;
		end
	end
endmodule : slx_tx_model
`default_nettype wire

// >>> verification/test_serial_lane_crossbar_and_prbs_check.sv
// Testbench for the lane crossbar and bit-error test block.
// Assumes slx_lane_xbar, slx_tx_model and slx_sva_chk are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_serial_lane_crossbar_and_prbs_check;
	// *****
	// Setup
	// *****
	logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, multiframe_end = 1'b0, prbs_on = 1'b0;
	logic avs_waitrequest;
	logic [11:0] avs_address = 12'h000;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [3:0] avs_byteenable = 4'hF;
	logic [7:0] disparity_error = 8'h00, not_in_table_error = 8'h00, unexpected_control_error = 8'h00;
	logic [7:0] lane_buffer_full = 8'hA5, lane_buffer_empty = 8'h5A, word = 8'h00, flip = 8'h00;
	logic [7:0] physical_serial_input, logical_lane_data, serial_phy_setup_value, q, c;
	logic [1:0] sync_request_output_n;
	int fails = 0, cmp_count = 0;
	localparam logic [9:0] IX [12] = '{10'h308, 10'h309, 10'h30A, 10'h30B, 10'h30C, 10'h30D,
		10'h312, 10'h314, 10'h315, 10'h316, 10'h31D, 10'h3FF};
	localparam logic [7:0] EX [12] = '{8'h08, 8'h1A, 8'h2C, 8'h3E, 8'hA5, 8'h5A,
		8'h10, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
	always #4 clk_sys = ~clk_sys;
	slx_lane_xbar DUT (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .physical_serial_input, .logical_lane_data,
		.lane_buffer_full, .lane_buffer_empty, .multiframe_end, .disparity_error, .not_in_table_error,
		.unexpected_control_error, .sync_request_output_n, .serial_phy_setup_value);
	slx_tx_model u_tx (.clk_sys, .rst, .prbs_on, .word, .flip, .lanes(physical_serial_input));
	// *****
	// Tasks
	// *****
	task give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("[FAIL] %s exp %h got %h", n, e, s);
			fails++;
		end
	endtask : chk
	// Request stands until waitrequest is sampled low at a rising edge; data is taken there
	task bus(input logic w, input logic [9:0] i, input logic [7:0] d, output logic [7:0] r);
		int n;
		@(posedge clk_sys);
		avs_address <= {i, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			$display("[FAIL] waitrequest exp 0 got 1");
			fails++;
			give_verdict();
		end
		r = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task wr(input logic [9:0] i, input logic [7:0] d);
		bus(1'b1, i, d, q);
	endtask : wr
	task rdc(input logic [9:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00, q);
		chk("reg", e, q);
	endtask : rdc
	task pulse(input logic [7:0] e);
		int lo;
		@(posedge clk_sys);
		multiframe_end <= 1'b1;
		@(posedge clk_sys);
		multiframe_end <= 1'b0;
		lo = 0;
		repeat (6) begin
			@(negedge clk_sys);
			if (sync_request_output_n === 2'b00)
				lo++;
		end
		chk("sync_low", e, 8'(lo));
	endtask : pulse
	task t_reset;
		foreach (IX[k]) rdc(IX[k], EX[k]);
		$display("reset test done");
	endtask : t_reset
	task t_xbar;
		wr(10'h308, 8'h37);
		wr(10'h309, 8'h25);
		wr(10'h30A, 8'h13);
		wr(10'h30B, 8'h01);
		word <= 8'hB4;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("lanes", 8'h2D, logical_lane_data);
		rdc(10'h309, 8'h25);
		wr(10'h30C, 8'hFF);
		rdc(10'h30C, 8'hA5);
		for (int k = 0; k < 4; k++) wr(IX[k], EX[k]);
		$display("crossbar test done");
	endtask : t_xbar
	task t_phy;
		wr(10'h314, 8'h01);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("phy", 8'h01, serial_phy_setup_value);
		rdc(10'h314, 8'h01);
		avs_byteenable <= 4'hE;
		wr(10'h314, 8'h55);
		avs_byteenable <= 4'hF;
		rdc(10'h314, 8'h01);
		$display("phy test done");
	endtask : t_phy
	task t_sync;
		for (int k = 0; k < 4; k++) begin
			wr(10'h312, 8'(k << 4));
			disparity_error <= (k == 0 || k == 3) ? 8'h01 : 8'h00;
			not_in_table_error <= (k == 1) ? 8'h10 : 8'h00;
			unexpected_control_error <= (k == 2) ? 8'h80 : 8'h00;
			@(posedge clk_sys);
			disparity_error <= 8'h00;
			not_in_table_error <= 8'h00;
			unexpected_control_error <= 8'h00;
			pulse(8'((k >= 2) ? 2 : 1));
		end
		pulse(8'h00);
		$display("sync test done");
	endtask : t_sync
	task t_bert;
		prbs_on <= 1'b1;
		wr(10'h315, 8'h04);
		wr(10'h316, 8'h22);
		repeat (20) @(posedge clk_sys);
		bus(1'b0, 10'h31A, 8'h00, c);
		// Lanes 2 and 5 both flipped, so either reading of lane mapping holds
		flip <= 8'h24;
		@(posedge clk_sys);
		flip <= 8'h00;
		repeat (20) @(posedge clk_sys);
		rdc(10'h31A, c + 8'h03);
		for (int p = 1; p < 3; p++) begin
			c = q;
			wr(10'h316, 8'(8'h22 | (p << 2)));
			repeat (20) @(posedge clk_sys);
			bus(1'b0, 10'h31A, 8'h00, q);
			chk("grow", 8'h01, 8'(q > c));
		end
		rdc(10'h31D, 8'hFB);
		wr(10'h316, 8'h32);
		rdc(10'h31A, 8'h00);
		wr(10'h316, 8'h21);
		rdc(10'h31A, 8'h00);
		rdc(10'h31D, 8'hFF);
		wr(10'h316, 8'h20);
		flip <= 8'h24;
		@(posedge clk_sys);
		flip <= 8'h00;
		rdc(10'h31A, 8'h00);
		// Seeding errors stay below a limit of 16, so lane 2 keeps passing
		wr(10'h317, 8'h10);
		wr(10'h316, 8'h22);
		repeat (20) @(posedge clk_sys);
		rdc(10'h31D, 8'hFF);
		rdc(10'h317, 8'h10);
		$display("bit error test done");
	endtask : t_bert
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_xbar();
		t_phy();
		t_sync();
		t_bert();
		give_verdict();
	end
endmodule : test_serial_lane_crossbar_and_prbs_check
bind slx_lane_xbar slx_sva_chk u_chk (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .lane_buffer_full,
	.lane_buffer_empty, .multiframe_end, .disparity_error, .not_in_table_error,
	.unexpected_control_error, .sync_request_output_n, .serial_phy_setup_value);
`default_nettype wire
